// *** design/fhf_fragmenter.v ***
// fronthaul fragmenter: transmit fragmentation, receive flow identification and reassembly check
//
// Decided for this implementation: the register offsets and the strobed register port.
`include "fhf_defines.vh"
`default_nettype none

// ****************************************
// word fifo
// ****************************************
module fhf_fifo #(
  parameter W = 32,
  parameter D = 8
) (
  // clock and reset
  input  wire         clk_i,
  input  wire         resetn_i,
  // fill side
  input  wire         in_valid_i,
  output wire         in_ready_o,
  input  wire [W-1:0] in_data_i,
  // drain side
  output wire         out_valid_o,
  input  wire         out_ready_i,
  output wire [W-1:0] out_data_o
);
  localparam AW = (D > 1) ? $clog2(D) : 1;

  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0]   count;
  wire         push;
  wire         pop;

  assign in_ready_o  = (count != D[AW:0]);
  assign out_valid_o = (count != {(AW+1){1'b0}});
  assign out_data_o  = mem[rd_ptr];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

  // storage needs no reset; valid is guarded by count
  always @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end
endmodule // fhf_fifo

// ****************************************
// top
// ****************************************
module fhf_fragmenter #(
  parameter ACI_W  = 2,
  parameter PORT_W = 4,
  parameter FIFO_D = 8
) (
  // clock and reset
  input  wire                     clk_i,
  input  wire                     resetn_i,
  // register port
  input  wire [7:0]               reg_addr_i,
  input  wire [31:0]              reg_wdata_i,
  input  wire                     reg_we_i,
  input  wire                     reg_re_i,
  output reg  [31:0]              reg_rdata_o,
  // transmit message stream
  input  wire                     tx_valid_i,
  output wire                     tx_ready_o,
  input  wire [31:0]              tx_data_i,
  input  wire                     tx_last_i,
  input  wire [ACI_W-1:0]         tx_aci_i,
  input  wire                     tx_plane_i,
  input  wire [`FHF_TAG_W-1:0]    tx_section_tag_i,
  input  wire [`FHF_BLK_W-1:0]    tx_first_block_i,
  // transmit fragment stream
  output reg                      frag_valid_o,
  input  wire                     frag_ready_i,
  output reg  [31:0]              frag_data_o,
  output reg                      frag_sof_o,
  output reg                      frag_eof_o,
  output reg  [`FHF_SEQ_W-1:0]    frag_seq_o,
  output reg                      frag_last_flag_o,
  output reg  [`FHF_IDX_W-1:0]    frag_index_o,
  output reg  [ACI_W-1:0]         frag_aci_o,
  output reg                      frag_plane_o,
  output reg  [`FHF_TAG_W-1:0]    frag_section_tag_o,
  output reg  [`FHF_BLK_W-1:0]    frag_first_block_o,
  output reg  [`FHF_BCNT_W-1:0]   frag_block_count_o,
  // receive header stream
  input  wire                     rx_valid_i,
  input  wire [11:0]              rx_vlan_i,
  input  wire [15:0]              rx_udp_port_i,
  input  wire [15:0]              rx_ethertype_i,
  input  wire [47:0]              rx_dmac_i,
  input  wire [PORT_W-1:0]        rx_port_i,
  input  wire [ACI_W-1:0]         rx_aci_i,
  input  wire [`FHF_SEQ_W-1:0]    rx_seq_i,
  input  wire                     rx_last_flag_i,
  input  wire [`FHF_IDX_W-1:0]    rx_index_i,
  // receive results
  output reg                      rx_cu_o,
  output reg                      rx_mgmt_o,
  output reg  [PORT_W+ACI_W-1:0]  rx_endpoint_o,
  output reg                      rx_msg_done_o,
  output reg                      rx_order_err_o
);
  localparam NACI = 1 << ACI_W;
  localparam FW   = 32 + 1 + ACI_W + 1 + `FHF_TAG_W + `FHF_BLK_W;

  // ****************************************
  // registers
  // ****************************************
  reg [3:0]              ctrl;
  reg [15:0]             mtu;
  reg [15:0]             overhead;
  reg [7:0]              block_words;
  reg [15:0]             udp_port;
  reg [15:0]             ethertype;
  reg [47:0]             mac;
  reg [15:0]             rx_msg_count;
  reg [15:0]             rx_err_count;
  reg [31:0]             tx_frag_count;
  reg [11:0]             vlan_tab [0:NACI-1];
  wire [15:0]            limit_bytes;
  wire [13:0]            limit_words;
  integer                i, ri, si, xi;

  assign limit_bytes = mtu - overhead;
  assign limit_words = limit_bytes[15:2];

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl        <= `FHF_RST_CTRL;
      mtu         <= `FHF_RST_MTU;
      overhead    <= `FHF_RST_OVERHEAD;
      block_words <= `FHF_RST_BLOCK_WORDS;
      udp_port    <= `FHF_RST_UDP_PORT;
      ethertype   <= `FHF_RST_ETHERTYPE;
      mac         <= 48'h0;
      for (i = 0; i < NACI; i = i + 1) begin
        vlan_tab[i] <= `FHF_RST_VLAN;
      end
    end else if (reg_we_i) begin
      case (reg_addr_i)
        `FHF_REG_CTRL:        ctrl        <= reg_wdata_i[3:0];
        `FHF_REG_MTU:         mtu         <= reg_wdata_i[15:0];
        `FHF_REG_OVERHEAD:    overhead    <= reg_wdata_i[15:0];
        `FHF_REG_BLOCK_WORDS: block_words <= reg_wdata_i[7:0];
        `FHF_REG_UDP_PORT:    udp_port    <= reg_wdata_i[15:0];
        `FHF_REG_ETHERTYPE:   ethertype   <= reg_wdata_i[15:0];
        `FHF_REG_MAC_LO:      mac[31:0]   <= reg_wdata_i;
        `FHF_REG_MAC_HI:      mac[47:32]  <= reg_wdata_i[15:0];
        default: begin
          for (i = 0; i < NACI; i = i + 1) begin
            if (reg_addr_i == `FHF_REG_VLAN_BASE + i[5:0] * 8'h04) begin
              vlan_tab[i] <= reg_wdata_i[11:0];
            end
          end
        end
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 32'h0;
    end else if (!reg_re_i) begin
      reg_rdata_o <= 32'h0;
    end else begin
      case (reg_addr_i)
        `FHF_REG_CTRL:        reg_rdata_o <= {28'h0, ctrl};
        `FHF_REG_MTU:         reg_rdata_o <= {16'h0, mtu};
        `FHF_REG_OVERHEAD:    reg_rdata_o <= {16'h0, overhead};
        `FHF_REG_BLOCK_WORDS: reg_rdata_o <= {24'h0, block_words};
        `FHF_REG_UDP_PORT:    reg_rdata_o <= {16'h0, udp_port};
        `FHF_REG_ETHERTYPE:   reg_rdata_o <= {16'h0, ethertype};
        `FHF_REG_MAC_LO:      reg_rdata_o <= mac[31:0];
        `FHF_REG_MAC_HI:      reg_rdata_o <= {16'h0, mac[47:32]};
        `FHF_REG_RX_STATUS:   reg_rdata_o <= {rx_err_count, rx_msg_count};
        `FHF_REG_TX_COUNT:    reg_rdata_o <= tx_frag_count;
        default: begin
          reg_rdata_o <= 32'h0;
          for (ri = 0; ri < NACI; ri = ri + 1) begin
            if (reg_addr_i == `FHF_REG_VLAN_BASE + ri[5:0] * 8'h04) begin
              reg_rdata_o <= {20'h0, vlan_tab[ri]};
            end
          end
        end
      endcase
    end
  end

  // ****************************************
  // transmit fifo
  // ****************************************
  wire          f_valid;
  wire          f_ready;
  wire [FW-1:0] f_data;

  fhf_fifo #(
    .W (FW),
    .D (FIFO_D)
  ) u_fifo (
    .clk_i       (clk_i),
    .resetn_i    (resetn_i),
    .in_valid_i  (tx_valid_i),
    .in_ready_o  (tx_ready_o),
    .in_data_i   ({tx_first_block_i, tx_section_tag_i, tx_plane_i, tx_aci_i, tx_last_i, tx_data_i}),
    .out_valid_o (f_valid),
    .out_ready_i (f_ready),
    .out_data_o  (f_data)
  );

  wire [31:0]            w_data  = f_data[31:0];
  wire                   w_last  = f_data[32];
  wire [ACI_W-1:0]       w_aci   = f_data[33 +: ACI_W];
  wire                   w_plane = f_data[33+ACI_W];
  wire [`FHF_TAG_W-1:0]  w_tag   = f_data[34+ACI_W +: `FHF_TAG_W];
  wire [`FHF_BLK_W-1:0]  w_blk   = f_data[34+ACI_W+`FHF_TAG_W +: `FHF_BLK_W];

  // ****************************************
  // transmit fragmentation
  // ****************************************
  localparam [1:0] S_IDLE = 2'b01;
  localparam [1:0] S_RUN  = 2'b10;

  reg [1:0]              state;
  reg                    msg_mode;
  reg                    new_frag;
  reg [13:0]             frag_words;
  reg [7:0]              blk_pos;
  reg [`FHF_BCNT_W-1:0]  blk_cnt;
  reg [`FHF_BLK_W-1:0]   blk_abs;
  reg [`FHF_BLK_W-1:0]   frag_first;
  reg [`FHF_IDX_W-1:0]   frag_idx;
  reg [`FHF_SEQ_W-1:0]   cur_seq;
  reg [`FHF_SEQ_W-1:0]   seq_tab [0:2*NACI-1];

  wire                   pop     = f_valid && f_ready;
  wire                   first   = (state == S_IDLE);
  wire                   mode    = first ? ctrl[`FHF_CTRL_MODE_BIT] : msg_mode;
  wire                   start   = first || new_frag;
  wire [ACI_W:0]         key     = {w_aci, w_plane};
  wire [13:0]            words   = start ? 14'h1 : frag_words + 14'h1;
  wire                   blk_end = (blk_pos + 8'h1 == block_words) || w_last;
  wire [`FHF_BCNT_W-1:0] bcnt    = (start ? {`FHF_BCNT_W{1'b0}} : blk_cnt) + {{(`FHF_BCNT_W-1){1'b0}}, blk_end};
  wire [14:0]            grow    = {1'b0, words} + {7'h0, block_words};
  wire                   app_cut = blk_end && (grow > {1'b0, limit_words});
  wire                   frag_end = w_last || (words >= limit_words) || (!mode && app_cut);
  wire [`FHF_BLK_W-1:0]  cur_abs = first ? w_blk : blk_abs;
  wire [`FHF_BLK_W-1:0]  first_use = start ? cur_abs : frag_first;
  wire [`FHF_SEQ_W-1:0]  seq_use = (first || !mode) && start ? seq_tab[key] : cur_seq;
  wire [`FHF_IDX_W-1:0]  idx_use = first ? {`FHF_IDX_W{1'b0}} : (new_frag ? frag_idx + 1'b1 : frag_idx);

  assign f_ready = !frag_valid_o || frag_ready_i;

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state      <= S_IDLE;
      msg_mode   <= 1'b0;
      new_frag   <= 1'b1;
      frag_words <= 14'h0;
      blk_pos    <= 8'h0;
      blk_cnt    <= {`FHF_BCNT_W{1'b0}};
      blk_abs    <= {`FHF_BLK_W{1'b0}};
      frag_first <= {`FHF_BLK_W{1'b0}};
      frag_idx   <= {`FHF_IDX_W{1'b0}};
      cur_seq    <= {`FHF_SEQ_W{1'b0}};
      tx_frag_count <= 32'h0;
      for (si = 0; si < 2*NACI; si = si + 1) begin
        seq_tab[si] <= {`FHF_SEQ_W{1'b0}};
      end
    end else if (pop) begin
      msg_mode   <= mode;
      new_frag   <= frag_end;
      frag_words <= words;
      blk_pos    <= blk_end ? 8'h0 : blk_pos + 8'h1;
      blk_cnt    <= bcnt;
      blk_abs    <= cur_abs + {{(`FHF_BLK_W-1){1'b0}}, blk_end};
      frag_first <= first_use;
      frag_idx   <= idx_use;
      cur_seq    <= seq_use;
      if (frag_end) begin
        tx_frag_count <= tx_frag_count + 32'h1;
      end
      // one step per fragment in mode 0 and per message in mode 1, wrapping at the top
      if ((!mode && frag_end) || (mode && w_last)) begin
        seq_tab[key] <= seq_use + 1'b1;
      end
      case (state)
        S_IDLE:  state <= w_last ? S_IDLE : S_RUN;
        S_RUN:   state <= w_last ? S_IDLE : S_RUN;
        default: state <= S_IDLE;
      endcase
    end
  end

  // registered output stage; header fields are final on the eof beat
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      frag_valid_o       <= 1'b0;
      frag_data_o        <= 32'h0;
      frag_sof_o         <= 1'b0;
      frag_eof_o         <= 1'b0;
      frag_seq_o         <= {`FHF_SEQ_W{1'b0}};
      frag_last_flag_o   <= 1'b0;
      frag_index_o       <= {`FHF_IDX_W{1'b0}};
      frag_aci_o         <= {ACI_W{1'b0}};
      frag_plane_o       <= 1'b0;
      frag_section_tag_o <= {`FHF_TAG_W{1'b0}};
      frag_first_block_o <= {`FHF_BLK_W{1'b0}};
      frag_block_count_o <= {`FHF_BCNT_W{1'b0}};
    end else if (f_ready) begin
      frag_valid_o       <= f_valid;
      frag_data_o        <= w_data;
      frag_sof_o         <= start;
      frag_eof_o         <= frag_end;
      frag_seq_o         <= seq_use;
      frag_last_flag_o   <= mode ? w_last : 1'b1;
      frag_index_o       <= mode ? idx_use : {`FHF_IDX_W{1'b0}};
      frag_aci_o         <= w_aci;
      frag_plane_o       <= w_plane;
      frag_section_tag_o <= w_tag;
      frag_first_block_o <= first_use;
      frag_block_count_o <= bcnt;
    end
  end

  // ****************************************
  // receive classification and order check
  // ****************************************
  reg                    cls_hit;
  reg [`FHF_SEQ_W-1:0]   rx_seq_tab [0:NACI-1];
  reg [`FHF_IDX_W-1:0]   rx_idx_tab [0:NACI-1];
  reg [NACI-1:0]         rx_busy;
  wire                   in_order;

  always @* begin
    case (ctrl[`FHF_CTRL_CLS_MSB:`FHF_CTRL_CLS_LSB])
      `FHF_CLS_UDP:   cls_hit = ctrl[`FHF_CTRL_L3_BIT] && (rx_udp_port_i == udp_port);
      `FHF_CLS_VLAN:  cls_hit = (rx_vlan_i == vlan_tab[rx_aci_i]);
      `FHF_CLS_MAC:   cls_hit = !ctrl[`FHF_CTRL_L3_BIT] && (rx_dmac_i == mac);
      `FHF_CLS_ETYPE: cls_hit = !ctrl[`FHF_CTRL_L3_BIT] && (rx_ethertype_i == ethertype);
      default:        cls_hit = 1'b0;
    endcase
  end

  // a piece is in order when it opens a message at zero or continues the open one
  assign in_order = rx_busy[rx_aci_i] ?
                    (rx_seq_i == rx_seq_tab[rx_aci_i] && rx_index_i == rx_idx_tab[rx_aci_i]) :
                    (rx_index_i == {`FHF_IDX_W{1'b0}});

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_cu_o        <= 1'b0;
      rx_mgmt_o      <= 1'b0;
      rx_endpoint_o  <= {(PORT_W+ACI_W){1'b0}};
      rx_msg_done_o  <= 1'b0;
      rx_order_err_o <= 1'b0;
      rx_msg_count   <= 16'h0;
      rx_err_count   <= 16'h0;
      rx_busy        <= {NACI{1'b0}};
      for (xi = 0; xi < NACI; xi = xi + 1) begin
        rx_seq_tab[xi] <= {`FHF_SEQ_W{1'b0}};
        rx_idx_tab[xi] <= {`FHF_IDX_W{1'b0}};
      end
    end else begin
      rx_cu_o        <= rx_valid_i && cls_hit;
      rx_mgmt_o      <= rx_valid_i && !cls_hit;
      rx_endpoint_o  <= {rx_port_i, rx_aci_i};
      rx_msg_done_o  <= 1'b0;
      rx_order_err_o <= 1'b0;
      if (rx_valid_i && cls_hit) begin
        if (in_order) begin
          rx_seq_tab[rx_aci_i] <= rx_seq_i;
          rx_idx_tab[rx_aci_i] <= rx_index_i + 1'b1;
          rx_busy[rx_aci_i]    <= !rx_last_flag_i;
          if (rx_last_flag_i) begin
            rx_msg_done_o <= 1'b1;
            rx_msg_count  <= rx_msg_count + 16'h1;
          end
        end else begin
          // a gap drops the partial message; counting lets software see loss
          rx_busy[rx_aci_i] <= 1'b0;
          rx_order_err_o    <= 1'b1;
          rx_err_count      <= rx_err_count + 16'h1;
        end
      end
    end
  end
endmodule // fhf_fragmenter

`default_nettype wire

// *** design/fhf_defines.vh ***
// constants of the fronthaul fragmenter: register offsets, fields, reset values
`ifndef FHF_DEFINES_VH
`define FHF_DEFINES_VH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define FHF_REG_CTRL        8'h00
`define FHF_REG_MTU         8'h04
`define FHF_REG_OVERHEAD    8'h08
`define FHF_REG_BLOCK_WORDS 8'h0c
`define FHF_REG_UDP_PORT    8'h10
`define FHF_REG_ETHERTYPE   8'h14
`define FHF_REG_MAC_LO      8'h18
`define FHF_REG_MAC_HI      8'h1c
`define FHF_REG_RX_STATUS   8'h20
`define FHF_REG_TX_COUNT    8'h24
`define FHF_REG_VLAN_BASE   8'h40

// ****************************************
// control fields
// ****************************************
`define FHF_CTRL_MODE_BIT   0
`define FHF_CTRL_CLS_LSB    1
`define FHF_CTRL_CLS_MSB    2
`define FHF_CTRL_L3_BIT     3

// ****************************************
// classifier methods
// ****************************************
`define FHF_CLS_UDP         2'h0
`define FHF_CLS_VLAN        2'h1
`define FHF_CLS_MAC         2'h2
`define FHF_CLS_ETYPE       2'h3

// ****************************************
// reset values
// ****************************************
`define FHF_RST_CTRL        4'h2
`define FHF_RST_MTU         16'h05dc
`define FHF_RST_OVERHEAD    16'h0008
`define FHF_RST_BLOCK_WORDS 8'h08
`define FHF_RST_UDP_PORT    16'h0000
`define FHF_RST_ETHERTYPE   16'h0000
`define FHF_RST_VLAN        12'h000

// ****************************************
// header field widths
// ****************************************
`define FHF_SEQ_W           8
`define FHF_IDX_W           7
`define FHF_TAG_W           12
`define FHF_BLK_W           10
`define FHF_BCNT_W          8

`endif

// *** verif/fhf_frag_sink.sv ***
// far-side fragment sink with random back-pressure
`default_nettype none
module fhf_frag_sink (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic resetn_i,
  // control and stream
  input  wire logic stop_i,
  input  wire logic frag_valid_i,
  output var  logic frag_ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // random stalls so that held beats are exercised; stop_i holds off all beats
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) frag_ready_o <= 1'b0;
    else frag_ready_o <= !stop_i && (!frag_valid_i || $urandom_range(3) != 0);
  end
endmodule // fhf_frag_sink
`default_nettype wire

// *** verif/fhf_fragmenter_monitor.sv ***
// assertion checker on the fronthaul fragmenter ports
`include "fhf_defines.vh"
`default_nettype none
module fhf_fragmenter_monitor #(
  parameter ACI_W  = 2,
  parameter PORT_W = 4
) (
  // clock, reset, register port
  input wire logic clk_i, resetn_i, reg_re_i,
  input wire logic [31:0] reg_rdata_o, frag_data_o,
  // fragment stream
  input wire logic frag_valid_o, frag_ready_i, frag_sof_o, frag_eof_o, frag_last_flag_o,
  input wire logic [`FHF_SEQ_W-1:0] frag_seq_o,
  input wire logic [`FHF_IDX_W-1:0] frag_index_o,
  // receive side
  input wire logic rx_valid_i, rx_last_flag_i, rx_cu_o, rx_mgmt_o, rx_msg_done_o, rx_order_err_o,
  input wire logic [PORT_W-1:0] rx_port_i,
  input wire logic [ACI_W-1:0] rx_aci_i,
  input wire logic [PORT_W+ACI_W-1:0] rx_endpoint_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // history of accepted fragments
  // ****
  logic in_frag, prev_flag;
  logic [`FHF_SEQ_W-1:0] prev_seq;
  logic [`FHF_IDX_W-1:0] prev_idx;
  // header fields are only final on the end beat, so history is taken there
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      in_frag <= 1'b0;
      prev_flag <= 1'b1;
      prev_seq <= 8'h00;
      prev_idx <= 7'h00;
    end else if (frag_valid_o && frag_ready_i) begin
      in_frag <= !frag_eof_o;
      if (frag_eof_o) begin
        prev_flag <= frag_last_flag_o;
        prev_seq <= frag_seq_o;
        prev_idx <= frag_index_o;
      end
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  rdata_idle_a: assert property (!reg_re_i |=> reg_rdata_o == 32'h0)
    else $error("read data outside read slot");
  frag_hold_a: assert property (frag_valid_o && !frag_ready_i |=> frag_valid_o && $stable(frag_data_o))
    else $error("stalled beat changed");
  frag_frame_a: assert property (frag_valid_o |-> frag_sof_o == !in_frag)
    else $error("fragment start misplaced");
  frag_seq_a: assert property (frag_valid_o && frag_eof_o && !prev_flag |-> frag_seq_o == prev_seq)
    else $error("sequence changed inside message");
  frag_index_a: assert property (frag_valid_o && frag_eof_o |->
    frag_index_o == (prev_flag ? 7'h00 : prev_idx + 7'h01)) else $error("fragment index out of order");
  rx_class_a: assert property (rx_valid_i |=> rx_cu_o != rx_mgmt_o)
    else $error("header not classified once");
  rx_quiet_a: assert property (!rx_valid_i |=> !(rx_cu_o || rx_mgmt_o || rx_msg_done_o || rx_order_err_o))
    else $error("receive pulse without header");
  rx_endpoint_a: assert property (rx_valid_i |=> rx_endpoint_o == $past({rx_port_i, rx_aci_i}))
    else $error("endpoint wrong");
  rx_done_a: assert property (rx_valid_i ##1 rx_msg_done_o |-> $past(rx_last_flag_i) && !rx_order_err_o)
    else $error("message done without last piece");
  cover property (frag_valid_o && frag_eof_o && !frag_last_flag_o);
  cover property (frag_valid_o && !frag_ready_i ##1 frag_valid_o);
  cover property (rx_order_err_o);
endmodule // fhf_fragmenter_monitor
`default_nettype wire

// *** verif/tb_fhf_fragmenter.sv ***
// testbench of the fronthaul fragmenter
`include "fhf_defines.vh"
`default_nettype none
module tb_fhf_fragmenter;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [47:0] MAC = 48'h02a1_b2c3_d4e5;
  logic clk_i = 0, resetn_i = 0, reg_we_i = 0, reg_re_i = 0, stop = 0, rd_d = 0, rx_d = 0;
  logic tx_valid_i = 0, tx_last_i = 0, tx_plane_i = 0, rx_valid_i = 0, rx_last_flag_i = 0;
  logic [7:0] reg_addr_i = 0, rx_seq_i = 0;
  logic [31:0] reg_wdata_i = 0, tx_data_i = 0;
  logic [1:0] tx_aci_i = 0, rx_aci_i = 0;
  logic [11:0] tx_section_tag_i = 0, rx_vlan_i = 0;
  logic [9:0] tx_first_block_i = 0;
  logic [15:0] rx_udp_port_i = 0, rx_ethertype_i = 0;
  logic [47:0] rx_dmac_i = 0;
  logic [3:0] rx_port_i = 0;
  logic [6:0] rx_index_i = 0;
  wire [31:0] reg_rdata_o, frag_data_o;
  wire tx_ready_o, frag_ready_i, frag_valid_o, frag_sof_o, frag_eof_o, frag_last_flag_o, frag_plane_o;
  wire [1:0] frag_aci_o;
  wire [11:0] frag_section_tag_o;
  wire [9:0] frag_first_block_o;
  wire [7:0] frag_seq_o, frag_block_count_o;
  wire [6:0] frag_index_o;
  wire rx_cu_o, rx_mgmt_o, rx_msg_done_o, rx_order_err_o;
  wire [5:0] rx_endpoint_o;
  int err_count = 0, comparisons = 0, k, tcnt = 0;
  logic [31:0] rq[$];
  logic [9:0] xq[$];
  logic [82:0] fq[$], e;
  logic [7:0] sq[8] = '{default: 8'h00};
  logic [3:0] cv[5] = '{4'h2, 4'h8, 4'h4, 4'h6, 4'h0};
  fhf_fragmenter DUT (.*);
  fhf_frag_sink sink (.clk_i(clk_i), .resetn_i(resetn_i), .stop_i(stop), .frag_valid_i(frag_valid_o),
    .frag_ready_o(frag_ready_i));
  always #10 clk_i = ~clk_i;
  // ****
  // shared tasks
  // ****
  task chk(input string n, input logic [82:0] g, input logic [82:0] x);
    comparisons++;
    if (g !== x) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", n, x, g);
    end
  endtask
  task final_report;
    $display("mismatches %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // a read passes its expected value as d
  task rg(input logic we, input logic [7:0] a, input logic [31:0] d);
    reg_we_i <= we;
    reg_re_i <= !we;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    if (!we) rq.push_back(d);
    @(posedge clk_i);
    reg_we_i <= 0;
    reg_re_i <= 0;
    @(posedge clk_i);
  endtask
  // limit is four words, blocks of two words, so fragments hold four words, the last of a message four or fewer
  task send(input int n, input logic md);
    logic [1:0] a;
    logic p;
    logic [9:0] fb;
    logic [11:0] tg;
    logic [31:0] d;
    int q, s;
    a = $urandom;
    p = $urandom;
    fb = $urandom_range(500);
    tg = $urandom;
    s = sq[{a, p}];
    for (int i = 0; i < n; i++) begin
      k = i / 4;
      q = i % 4;
      d = $urandom;
      tx_valid_i <= 1;
      tx_data_i <= d;
      tx_last_i <= (i == n - 1);
      tx_aci_i <= a;
      tx_plane_i <= p;
      tx_section_tag_i <= tg;
      tx_first_block_i <= fb;
      fq.push_back({d, q == 0, q == 3 || i == n - 1, 8'(md ? s : s + k), md ? i == n - 1 : 1'b1,
        7'(md ? k : 0), 10'(fb + 2 * k), 8'((q + 2) / 2), tg, a, p});
      do @(negedge clk_i); while (tx_ready_o !== 1'b1);
      @(posedge clk_i);
    end
    tx_valid_i <= 0;
    sq[{a, p}] = s + (md ? 1 : (n + 3) / 4);
    tcnt += (n + 3) / 4;
    @(posedge clk_i);
  endtask
  task drain;
    for (int j = 0; j < 800 && fq.size() != 0; j++) @(posedge clk_i);
    chk("drain", fq.size(), 0);
  endtask
  // matching headers carry aci 1 and every configured flow field
  task rx(input logic m, input logic [7:0] s, input logic [6:0] x, input logic f, input logic [3:0] r);
    logic [3:0] pt;
    pt = $urandom;
    rx_valid_i <= 1;
    rx_vlan_i <= m ? 12'h0a5 : 12'h35a;
    rx_udp_port_i <= m ? 16'h1234 : 16'h4321;
    rx_ethertype_i <= m ? 16'haefe : 16'h0800;
    rx_dmac_i <= m ? MAC : ~MAC;
    rx_port_i <= pt;
    rx_aci_i <= 2'h1;
    rx_seq_i <= s;
    rx_index_i <= x;
    rx_last_flag_i <= f;
    xq.push_back({r, pt, 2'h1});
    @(posedge clk_i);
  endtask
  // ****
  // result watcher
  // ****
  always @(posedge clk_i) begin
    if (rd_d) chk("rdata", reg_rdata_o, rq.pop_front());
    if (rx_d) chk("rx", {rx_cu_o, rx_mgmt_o, rx_msg_done_o, rx_order_err_o, rx_endpoint_o}, xq.pop_front());
    if (frag_valid_o && frag_ready_i) begin
      e = fq.pop_front();
      chk("beat", {frag_data_o, frag_sof_o, frag_eof_o}, e[82:49]);
      if (frag_eof_o) chk("hdr", {frag_seq_o, frag_last_flag_o, frag_index_o, frag_first_block_o,
        frag_block_count_o, frag_section_tag_o, frag_aci_o, frag_plane_o}, e[48:0]);
    end
    rd_d <= reg_re_i;
    rx_d <= rx_valid_i;
  end
  initial begin
    repeat (60000) @(posedge clk_i);
    err_count++;
    final_report;
  end
  initial begin
    void'($urandom(32'hb6f21389));
    repeat (8) @(posedge clk_i);
    resetn_i <= 1;
    @(posedge clk_i);
    rg(0, `FHF_REG_MTU, 32'h5dc);
    rg(0, `FHF_REG_OVERHEAD, 32'h8);
    rg(0, `FHF_REG_CTRL, 32'h2);
    rg(0, `FHF_REG_BLOCK_WORDS, 32'h8);
    rg(0, 8'h30, 32'h0);
    rg(1, `FHF_REG_MTU, 32'd24);
    rg(1, `FHF_REG_BLOCK_WORDS, 32'h2);
    for (int m = 0; m < 2; m++) begin
      rg(1, `FHF_REG_CTRL, 32'h2 | m);
      repeat (8) send($urandom_range(1, 12), m);
      drain;
    end
    stop <= 1;
    fork
      send(12, 1);
    join_none
    repeat (40) @(posedge clk_i);
    chk("tx_ready", tx_ready_o, 0);
    stop <= 0;
    drain;
    rg(0, `FHF_REG_TX_COUNT, tcnt);
    rg(1, `FHF_REG_VLAN_BASE + 8'h04, 32'h0a5);
    rg(0, `FHF_REG_VLAN_BASE + 8'h04, 32'h0a5);
    rg(1, `FHF_REG_UDP_PORT, 32'h1234);
    rg(1, `FHF_REG_ETHERTYPE, 32'haefe);
    rg(1, `FHF_REG_MAC_LO, MAC[31:0]);
    rg(1, `FHF_REG_MAC_HI, {16'h0, MAC[47:32]});
    for (int i = 0; i < 5; i++) begin
      rg(1, `FHF_REG_CTRL, cv[i]);
      rx(1, 8'h10, 0, 1, cv[i] != 0 ? 4'b1010 : 4'b0100);
      rx(0, 8'h20, 0, 1, 4'b0100);
      rx_valid_i <= 0;
      @(posedge clk_i);
    end
    rg(1, `FHF_REG_CTRL, 32'h2);
    rx(1, 8'h05, 0, 0, 4'b1000);
    rx(1, 8'h05, 1, 0, 4'b1000);
    rx(1, 8'h05, 2, 1, 4'b1010);
    rx(1, 8'h06, 0, 0, 4'b1000);
    rx(1, 8'h06, 2, 1, 4'b1001);
    rx(1, 8'h07, 0, 0, 4'b1000);
    rx(1, 8'h08, 1, 1, 4'b1001);
    rx_valid_i <= 0;
    repeat (4) @(posedge clk_i);
    rg(0, `FHF_REG_RX_STATUS, 32'h0002_0005);
    @(posedge clk_i);
    chk("left", xq.size() + rq.size(), 0);
    final_report;
  end
endmodule // tb_fhf_fragmenter
bind fhf_fragmenter fhf_fragmenter_monitor #(.ACI_W(ACI_W), .PORT_W(PORT_W)) mon (.*);
`default_nettype wire
